// file: jtsm_consts.svh
// Constants for the transport sample mapper
`ifndef JTSM_CONSTS_SVH
`define JTSM_CONSTS_SVH
`define JTSM_SW     9
`define JTSM_NCH    4
`define JTSM_NSMP   4
`define JTSM_NLANE  6
`define JTSM_LW     40
`define JTSM_FDEPTH 4
`define JTSM_M1     4'h1
`define JTSM_M2     4'h2
`define JTSM_M3     4'h3
`define JTSM_M4     4'h4
`define JTSM_M5     4'h5
`define JTSM_M6     4'h6
`define JTSM_M7     4'h7
`define JTSM_M8     4'h8
`define JTSM_OCT_1  3'h1
`define JTSM_OCT_2  3'h2
`define JTSM_OCT_3  3'h3
`define JTSM_OCT_5  3'h5
`define JTSM_T3     3'h0
`define JTSM_T1     1'h0
`define JTSM_Z8     8'h00
`define JTSM_NL_1   3'h1
`define JTSM_NL_2   3'h2
`define JTSM_NL_3   3'h3
`define JTSM_NL_4   3'h4
`define JTSM_NL_6   3'h6
`endif

// file: jtsm_mapper.sv
// Frame FIFO and lane sample mapper of the transport layer
//
// Functional notes
// - Mode 1: padded A0 then A1 top nibble
// - Mode 1 lane 1: A1 low, B0 top
// - Mode 1 lane 2: B0 bit0, B1 padded
// - Mode 2: one 8-bit sample per lane
// - Mode 3: four 10-bit samples per lane
// - Mode 4 lane 0: A padded, B top
// - Mode 5: A then B on lane 0
// - Mode 6 packs like mode 1
// - Mode 7: one 8-bit sample per lane
// - Mode 8: two 12-bit samples per lane
// - MSB first, extra low bits zero
// - Tail and filler bits are zero
// - Lowest lanes used, higher lanes off
`include "jtsm_consts.svh"
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////
// Synchronous FIFO, width and depth as parameters
module jtsm_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input  wire logic         clk_sys,  // System clock
  input  wire logic         rst_n,    // Async reset, low
  input  wire logic         ce,       // Clock enable
  input  wire logic         wr_valid, // Write valid
  output logic              wr_ready, // Not full
  input  wire logic [W-1:0] wr_data,  // Write word
  output logic              rd_valid, // Not empty
  input  wire logic         rd_ready, // Reader takes word
  output logic [W-1:0]      rd_data   // Head word
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   cnt;
  logic          wr_go;
  logic          rd_go;

  // Full and empty come straight from the count
  assign wr_ready = (cnt != (AW+1)'(D)) ? 1'b1 : 1'b0;
  assign rd_valid = (cnt != '0);
  assign rd_data  = mem[rp];
  assign wr_go    = ce & wr_valid & wr_ready;
  assign rd_go    = ce & rd_valid & rd_ready;

  // Storage, no reset needed on data
  always_ff @(posedge clk_sys) begin
    if (wr_go) begin
      mem[wp] <= wr_data;
    end
  end

  // Pointers wrap at depth
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (wr_go) begin
        wp <= (wp == AW'(D - 1)) ? '0 : wp + 1'b1;
      end
      if (rd_go) begin
        rp <= (rp == AW'(D - 1)) ? '0 : rp + 1'b1;
      end
    end
  end

  // Occupancy
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (wr_go && !rd_go) begin
      cnt <= cnt + 1'b1;
    end else if (rd_go && !wr_go) begin
      cnt <= cnt - 1'b1;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////
// Mapper top: frames in, per-lane octets out
module jtsm_mapper #(
  parameter int FDEPTH = `JTSM_FDEPTH
) (
  input  wire logic              clk_sys,          // System clock
  input  wire logic              rst_n,            // Async reset, low
  input  wire logic              ce,               // Clock enable
  input  wire logic [3:0]        link_mode_select, // Link mode 1..8
  input  wire jtsm_pkg::jtsm_var_t variant,        // Quad, dual, single
  input  wire logic              in_valid,         // Frame offered
  output logic                   in_ready,         // FIFO has room
  input  wire jtsm_pkg::jtsm_frame_t in_frame,     // Samples of a frame
  output logic                   out_valid,        // Lane frame valid
  input  wire logic              out_ready,        // Link layer takes it
  output jtsm_pkg::jtsm_lanes_t  out_lanes         // Lane octets
);
  import jtsm_pkg::*;

  jtsm_frame_t f_data;
  logic        f_valid;
  logic        f_ready;
  logic        pop;
  jtsm_state_t state;

  ////////////////////////////////////////////////////////////////////
  // Sample padding helpers
  function automatic logic [11:0] p12(input logic [`JTSM_SW-1:0] s);
    p12 = {s, `JTSM_T3};
  endfunction

  function automatic logic [9:0] p10(input logic [`JTSM_SW-1:0] s);
    p10 = {s, `JTSM_T1};
  endfunction

  // 8-bit modes keep the top eight bits of the sample
  function automatic logic [7:0] s8(input logic [`JTSM_SW-1:0] s);
    s8 = s[`JTSM_SW-1 -: 8];
  endfunction

  // Lanes in use for a mode and variant
  function automatic logic [2:0] nlanes(input logic [3:0] m, input jtsm_var_t v);
    logic q;
    logic d;
    q = (v == JTSM_QUAD);
    d = (v == JTSM_DUAL);
    case (m)
      `JTSM_M1, `JTSM_M6: nlanes = q ? `JTSM_NL_6 : (d ? `JTSM_NL_3 : `JTSM_NL_2);
      `JTSM_M4:           nlanes = q ? `JTSM_NL_3 : (d ? `JTSM_NL_2 : `JTSM_NL_1);
      `JTSM_M5:           nlanes = q ? `JTSM_NL_2 : `JTSM_NL_1;
      `JTSM_M2, `JTSM_M3, `JTSM_M7, `JTSM_M8:
        nlanes = q ? `JTSM_NL_4 : (d ? `JTSM_NL_2 : `JTSM_NL_1);
      default:            nlanes = '0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Frame to lane mapping
  function automatic jtsm_lanes_t map(input jtsm_frame_t fi, input logic [3:0] m,
                                     input jtsm_var_t v);
    jtsm_frame_t f;
    jtsm_lanes_t r;
    logic [95:0] w12;
    logic [47:0] w4;
    logic [31:0] w8;
    logic [2:0]  nl;
    r  = '0;
    f  = fi;
    // Absent channels become zero filler, which yields the 0x00 octets
    if (v == JTSM_SINGLE) begin
      f.smp[1] = '0;
    end
    if (v != JTSM_QUAD) begin
      f.smp[2] = '0;
      f.smp[3] = '0;
    end
    w12 = {p12(f.smp[0][0]), p12(f.smp[0][1]), p12(f.smp[1][0]), p12(f.smp[1][1]),
           p12(f.smp[2][0]), p12(f.smp[2][1]), p12(f.smp[3][0]), p12(f.smp[3][1])};
    w4  = {p12(f.smp[0][0]), p12(f.smp[1][0]), p12(f.smp[2][0]), p12(f.smp[3][0])};
    w8  = {s8(f.smp[0][0]), s8(f.smp[1][0]), s8(f.smp[2][0]), s8(f.smp[3][0])};
    nl  = nlanes(m, v);
    case (m)
      // One 12-bit stream cut into 16-bit lane frames
      `JTSM_M1, `JTSM_M6: begin
        r.n_oct = `JTSM_OCT_2;
        for (int i = 0; i < 6; i++) begin
          r.oct[i][`JTSM_LW-1 -: 16] = w12[95-16*i -: 16];
        end
      end
      // Single-sample 12-bit stream over three lanes
      `JTSM_M4: begin
        r.n_oct = `JTSM_OCT_2;
        for (int i = 0; i < 3; i++) begin
          r.oct[i][`JTSM_LW-1 -: 16] = w4[47-16*i -: 16];
        end
      end
      // Two 8-bit samples per lane
      `JTSM_M5: begin
        r.n_oct = `JTSM_OCT_2;
        for (int i = 0; i < 2; i++) begin
          r.oct[i][`JTSM_LW-1 -: 16] = w8[31-16*i -: 16];
        end
      end
      // One channel per lane, one 8-bit sample
      `JTSM_M2, `JTSM_M7: begin
        r.n_oct = `JTSM_OCT_1;
        for (int i = 0; i < 4; i++) begin
          r.oct[i][`JTSM_LW-1 -: 8] = s8(f.smp[i][0]);
        end
      end
      // One channel per lane, four 10-bit samples
      `JTSM_M3: begin
        r.n_oct = `JTSM_OCT_5;
        for (int i = 0; i < 4; i++) begin
          r.oct[i] = {p10(f.smp[i][0]), p10(f.smp[i][1]),
                      p10(f.smp[i][2]), p10(f.smp[i][3])};
        end
      end
      // One channel per lane, two 12-bit samples
      `JTSM_M8: begin
        r.n_oct = `JTSM_OCT_3;
        for (int i = 0; i < 4; i++) begin
          r.oct[i][`JTSM_LW-1 -: 24] = {p12(f.smp[i][0]), p12(f.smp[i][1])};
        end
      end
      default: begin
        r.n_oct = '0;
      end
    endcase
    // Unused lanes idle at zero, so the powered-down drivers see no toggles
    for (int i = 0; i < `JTSM_NLANE; i++) begin
      r.lane_en[i] = (3'(i) < nl);
      if (!r.lane_en[i]) begin
        r.oct[i] = '0;
      end
    end
    map = r;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Input buffer absorbs bursts while the link layer stalls
  jtsm_fifo #(
    .W ($bits(jtsm_frame_t)),
    .D (FDEPTH)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .ce       (ce),
    .wr_valid (in_valid),
    .wr_ready (in_ready),
    .wr_data  (in_frame),
    .rd_valid (f_valid),
    .rd_ready (f_ready),
    .rd_data  (f_data)
  );

  // Output slot empties or drains this cycle
  assign f_ready   = (state == JTSM_S_IDLE) || out_ready;
  assign pop       = ce & f_valid & f_ready;
  assign out_valid = (state == JTSM_S_HOLD);

  // Slot state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= JTSM_S_IDLE;
    end else if (ce) begin
      case (state)
        JTSM_S_IDLE: begin
          if (pop) begin
            state <= JTSM_S_HOLD;
          end
        end
        JTSM_S_HOLD: begin
          if (out_ready && !pop) begin
            state <= JTSM_S_IDLE;
          end
        end
        default: state <= JTSM_S_IDLE;
      endcase
    end
  end

  // Mapped lane data, mode sampled per frame
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_lanes <= '0;
    end else if (pop) begin
      out_lanes <= map(f_data, link_mode_select, variant);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks: helper copy of what was popped
  jtsm_frame_t c_f;
  logic [3:0]  c_m;
  jtsm_var_t   c_v;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      c_f <= '0;
      c_m <= '0;
      c_v <= JTSM_QUAD;
    end else if (pop) begin
      c_f <= f_data;
      c_m <= link_mode_select;
      c_v <= variant;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_M1_L0: assert property (out_valid && c_m == `JTSM_M1 |->
    out_lanes.oct[0][39:24] == {c_f.smp[0][0], 3'h0, c_f.smp[0][1][8:5]})
    else $error("mode 1 lane 0 mismatch");
  AST_M1_L1: assert property (out_valid && c_m == `JTSM_M1 && c_v == JTSM_SINGLE |->
    out_lanes.oct[1][39:24] == {c_f.smp[0][1][4:0], 3'h0, 8'h00})
    else $error("mode 1 single lane 1 mismatch");
  AST_M1_L2: assert property (out_valid && c_m == `JTSM_M1 && c_v != JTSM_SINGLE |->
    out_lanes.oct[2][39:24] == {c_f.smp[1][0][0], 3'h0, c_f.smp[1][1], 3'h0})
    else $error("mode 1 lane 2 mismatch");
  AST_M2_L3: assert property (out_valid && c_m == `JTSM_M2 && c_v == JTSM_QUAD |->
    out_lanes.oct[3][39:32] == c_f.smp[3][0][8:1] && out_lanes.n_oct == 3'h1)
    else $error("mode 2 lane 3 mismatch");
  AST_M3_L0: assert property (out_valid && c_m == `JTSM_M3 |->
    out_lanes.oct[0] == {c_f.smp[0][0], 1'b0, c_f.smp[0][1], 1'b0,
                         c_f.smp[0][2], 1'b0, c_f.smp[0][3], 1'b0})
    else $error("mode 3 lane 0 mismatch");
  AST_M4_L0: assert property (out_valid && c_m == `JTSM_M4 && c_v == JTSM_SINGLE |->
    out_lanes.oct[0][39:24] == {c_f.smp[0][0], 3'h0, 4'h0})
    else $error("mode 4 single lane 0 mismatch");
  AST_M4_L1: assert property (out_valid && c_m == `JTSM_M4 && c_v == JTSM_QUAD |->
    out_lanes.oct[1][31:24] == c_f.smp[2][0][8:1] && out_lanes.oct[2][35:24] == {c_f.smp[3][0], 3'h0})
    else $error("mode 4 quad lane 1 or 2 mismatch");
  AST_M5_L1: assert property (out_valid && c_m == `JTSM_M5 && c_v == JTSM_QUAD |->
    out_lanes.oct[1][39:24] == {c_f.smp[2][0][8:1], c_f.smp[3][0][8:1]})
    else $error("mode 5 quad lane 1 mismatch");
  AST_M8_L1: assert property (out_valid && c_m == `JTSM_M8 && c_v != JTSM_SINGLE |->
    out_lanes.oct[1][39:16] == {c_f.smp[1][0], 3'h0, c_f.smp[1][1], 3'h0} && out_lanes.n_oct == 3'h3)
    else $error("mode 8 lane 1 mismatch");
  AST_IDLE_LANES: assert property (out_valid && c_m == `JTSM_M7 && c_v == JTSM_SINGLE |->
    out_lanes.lane_en == 6'h01 && out_lanes.oct[1] == '0 && out_lanes.oct[5] == '0)
    else $error("unused lane not idle");
  AST_POP_SHOWS: assert property (pop |=> out_valid && c_m == $past(link_mode_select))
    else $error("popped frame not presented");

  COV_M1_QUAD: cover property (out_valid && out_ready && c_m == `JTSM_M1 && c_v == JTSM_QUAD);
  COV_M3_DUAL: cover property (out_valid && out_ready && c_m == `JTSM_M3 && c_v == JTSM_DUAL);
  COV_STALL:   cover property (!in_ready ##1 out_ready [*2]);
  COV_B2B:     cover property (pop ##1 pop);
endmodule

`default_nettype wire

// file: jtsm_mapper_tb_top.sv
// Self-checking bench of the transport sample mapper
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module jtsm_mapper_tb_top;
  import jtsm_pkg::*;
  localparam int FD = 4;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic [3:0]  mode = 4'h1;
  jtsm_var_t   vsel = JTSM_QUAD;
  logic        in_valid = 1'b0;
  logic        stall = 1'b0;
  logic        in_ready;
  logic        out_valid;
  logic        out_ready;
  jtsm_frame_t frame = '0;
  jtsm_lanes_t lanes;
  jtsm_lanes_t exp_q[$];
  int          n_errors = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  ////////////////////////////////////////////////////////////////////////
  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;
  jtsm_mapper #(.FDEPTH(FD)) jtsm_mapper_inst (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
    .link_mode_select(mode), .variant(vsel), .in_valid(in_valid), .in_ready(in_ready),
    .in_frame(frame), .out_valid(out_valid), .out_ready(out_ready), .out_lanes(lanes));
  jtsm_rx_model jtsm_rx_model_inst (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .stall(stall),
    .out_valid(out_valid), .out_ready(out_ready), .out_lanes(lanes));
  ////////////////////////////////////////////////////////////////////////
  // Expected lanes: all padded samples as one MSB-first stream, cut per lane
  function automatic jtsm_lanes_t exp_map(logic [3:0] m, jtsm_var_t v, jtsm_frame_t f);
    jtsm_lanes_t  r;
    logic [159:0] st;
    logic [159:0] t;
    logic [8:0]   s;
    int pw, ns, bpl, nl, tot, keep;
    r = '0;
    st = '0;
    tot = 0;
    keep = (v == JTSM_QUAD) ? 4 : (v == JTSM_DUAL) ? 2 : 1;
    pw = (m == 4'h3) ? 10 : (m == 4'h2 || m == 4'h5 || m == 4'h7) ? 8 : 12;
    ns = (m == 4'h3) ? 4 : (m == 4'h1 || m == 4'h6 || m == 4'h8) ? 2 : 1;
    bpl = (m == 4'h2 || m == 4'h7) ? 8 : (m == 4'h3) ? 40 : (m == 4'h8) ? 24 : 16;
    case (m)
      4'h1, 4'h6: nl = (v == JTSM_QUAD) ? 6 : (v == JTSM_DUAL) ? 3 : 2;
      4'h4: nl = (v == JTSM_QUAD) ? 3 : (v == JTSM_DUAL) ? 2 : 1;
      4'h5: nl = (v == JTSM_QUAD) ? 2 : 1;
      4'h2, 4'h3, 4'h7, 4'h8: nl = keep;
      default: nl = 0;
    endcase
    for (int c = 0; c < 4; c++) begin
      for (int n = 0; n < ns; n++) begin
        s = (c < keep) ? f.smp[c][n] : 9'h000;
        st = (st << pw) | ((pw == 8) ? 160'(s[8:1]) : (160'(s) << (pw - 9)));
        tot += pw;
      end
    end
    st = st << (160 - tot);
    for (int i = 0; i < nl; i++) begin
      t = st << (bpl * i);
      r.oct[i] = t[159:120] & ~(40'hFFFFFFFFFF >> bpl);
    end
    r.n_oct = (nl == 0) ? 3'h0 : 3'(bpl / 8);
    r.lane_en = 6'((1 << nl) - 1);
    return r;
  endfunction
  // Frame with distinct values in every slot
  function automatic jtsm_frame_t mk(int k);
    jtsm_frame_t f;
    for (int c = 0; c < 4; c++) begin
      for (int n = 0; n < 4; n++) f.smp[c][n] = 9'(k * 97 + c * 41 + n * 13 + 5);
    end
    return f;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // Offer a frame and leave valid up so the next one may follow at once
  task automatic push(jtsm_frame_t f);
    int k;
    k = 0;
    frame = f;
    in_valid = 1'b1;
    exp_q.push_back(exp_map(mode, vsel, f));
    while (in_ready !== 1'b1 && k < 50) begin
      @(negedge clk_sys);
      k++;
    end
    @(negedge clk_sys);
  endtask
  // Stop offering, wait for the receiver, compare in order
  task automatic drain();
    int k;
    in_valid = 1'b0;
    k = 0;
    while (jtsm_rx_model_inst.rx_q.size() < exp_q.size() && k < 100) begin
      @(negedge clk_sys);
      k++;
    end
    repeat (2) @(negedge clk_sys);
    `CHK(jtsm_rx_model_inst.rx_q.size(), exp_q.size())
    foreach (exp_q[i]) `CHK(jtsm_rx_model_inst.rx_q[i], exp_q[i])
    exp_q.delete();
    jtsm_rx_model_inst.rx_q.delete();
  endtask
  // Every mode and variant, invalid modes too, back-to-back frames
  task automatic t_modes();
    for (int m = 0; m < 10; m++) begin
      for (int v = 0; v < 3; v++) begin
        mode = 4'(m);
        vsel = jtsm_var_t'(v);
        push(mk(m * 3 + v));
        push('1);
        drain();
      end
    end
  endtask
  // Stalled receiver: slot plus FIFO fill, then refuse, then drain in order
  task automatic t_fifo();
    mode = 4'h1;
    vsel = JTSM_QUAD;
    stall = 1'b1;
    for (int i = 0; i < FD + 1; i++) push(mk(100 + i));
    in_valid = 1'b0;
    repeat (4) @(negedge clk_sys);
    `CHK(in_ready, 1'b0)
    `CHK(jtsm_rx_model_inst.rx_q.size(), 0)
    stall = 1'b0;
    drain();
  endtask
  // Clock enable low freezes intake; frame is taken once it returns
  task automatic t_ce();
    mode = 4'h2;
    vsel = JTSM_DUAL;
    ce = 1'b0;
    push(mk(7));
    repeat (3) @(negedge clk_sys);
    `CHK(jtsm_rx_model_inst.rx_q.size(), 0)
    ce = 1'b1;
    @(negedge clk_sys);
    drain();
  endtask
  // Reset in mid-run drops the held frame and idles both sides
  task automatic t_reset();
    `CHK(in_ready, 1'b1)
    stall = 1'b1;
    push(mk(9));
    in_valid = 1'b0;
    repeat (3) @(negedge clk_sys);
    `CHK(out_valid, 1'b1)
    rst_n = 1'b0;
    @(negedge clk_sys);
    `CHK(out_valid, 1'b0)
    `CHK(in_ready, 1'b1)
    `CHK(lanes, jtsm_lanes_t'(0))
    rst_n = 1'b1;
    stall = 1'b0;
    exp_q.delete();
    repeat (3) @(negedge clk_sys);
    `CHK(out_valid, 1'b0)
    `CHK(jtsm_rx_model_inst.rx_q.size(), 0)
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic final_report();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      final_report();
    end
  end
  // Main sequence
  initial begin
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    t_modes();
    t_fifo();
    t_ce();
    t_reset();
    final_report();
  end
endmodule
`default_nettype wire

// file: jtsm_pkg.sv
// Types for the transport sample mapper
`include "jtsm_consts.svh"
package jtsm_pkg;
  // Device variant
  typedef enum logic [1:0] {
    JTSM_QUAD   = 2'h0,
    JTSM_DUAL   = 2'h1,
    JTSM_SINGLE = 2'h2
  } jtsm_var_t;
  // Output slot state, one-hot
  typedef enum logic [1:0] {
    JTSM_S_IDLE = 2'h1,
    JTSM_S_HOLD = 2'h2
  } jtsm_state_t;
  // One frame: smp[channel][sample index], channel 0 is A
  typedef struct packed {
    logic [`JTSM_NCH-1:0][`JTSM_NSMP-1:0][`JTSM_SW-1:0] smp;
  } jtsm_frame_t;
  // Lane octets, octet 0 in the top byte of each lane word
  typedef struct packed {
    logic [`JTSM_NLANE-1:0][`JTSM_LW-1:0] oct;
    logic [2:0]                           n_oct;
    logic [`JTSM_NLANE-1:0]               lane_en;
  } jtsm_lanes_t;
endpackage

// file: jtsm_rx_model.sv
// Link receiver model that takes lane frames from the mapper
`timescale 1ns/1ps
`default_nettype none
module jtsm_rx_model (
  input  wire logic                  clk_sys,   // System clock
  input  wire logic                  rst_n,     // Async reset, low
  input  wire logic                  ce,        // Clock enable
  input  wire logic                  stall,     // Bench asks for a slow receiver
  input  wire logic                  out_valid, // Lane frame offered
  output logic                       out_ready, // Receiver takes it
  input  wire jtsm_pkg::jtsm_lanes_t out_lanes  // Lane octets
);
  import jtsm_pkg::*;
  jtsm_lanes_t rx_q[$]; // Frames taken, oldest first
  ////////////////////////////////////////////////////////////////////////
  // Ready moves by non-blocking update on the rising edge, stall is settled by then
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) out_ready <= 1'b0;
    else out_ready <= !stall;
  end
  // Capture at the handshake edge; lanes wired lowest index first
  always @(posedge clk_sys) begin
    if (rst_n && ce && out_valid && out_ready) rx_q.push_back(out_lanes);
  end
endmodule
`default_nettype wire
